// File: design/event_mask_ctl.sv
// function event mask with event latch, wakeup gating and audio select
// assumes pin inputs are asynchronous; audio sources are on clk
// Function
// - latched event raises status-change interrupt or wakeup only when its enable is one
// - each instance is one function with its own private mask copy
// - master wake enable gates wakeup apart from per-event enables
// - bit 0 gates write-protect change to interrupt, wakeup needs master
// - bit 1 gates busy-to-ready the same way
// - bits 2-3 gate both battery events; 11 enables, 00 blocks
// - wake-capable enables and the master gate survive card reset; others clear to zero
// - bit 4 gates general wake to wakeup only, never interrupt
// - bit 4 exists and is kept only if general wake is built
// - bit 5 enables binary audio on the audio pin, resets zero
// - bit 6 enables pwm audio on the audio pin, resets zero
// - mask register reads back every implemented bit written
// - bit 14 zero blocks all wakeup whatever per-event bits hold
// - the event latch is the source that the mask gates
//
// Our own choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`default_nettype none
module event_mask_ctl #(
    parameter int         ADDR_W      = 8,
    parameter bit         GEN_WK_IMPL = 1'b1,
    parameter logic [4:0] WAKE_CAP    = 5'h1F
) (
    input  wire logic              clk,
    input  wire logic              rstn,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [31:0]       wdata,
    input  wire logic              wr,
    input  wire logic              rd,
    output logic      [31:0]       rdata,
    input  wire logic              wp_pin,
    input  wire logic              ready_pin,
    input  wire logic              battery_level_high_bit,
    input  wire logic              battery_level_low_bit,
    input  wire logic              general_wake_event,
    input  wire logic              card_rst_n_pin,
    input  wire logic              binary_audio_src,
    input  wire logic              pwm_audio_src,
    output logic                   status_change_irq,
    output logic                   wake_req,
    output logic                   card_audio_pin,
    output logic                   irq
);
    localparam int N = evmask_pkg::N_EVT;

    // ------------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------------
    if (ADDR_W < 4 || ADDR_W > 8) begin : g_chk
        $error("ADDR_W must lie between 4 and 8");
    end

    localparam logic [31:0] IMPL = evmask_pkg::MASK_IMPL_BASE |
        (GEN_WK_IMPL ? evmask_pkg::MASK_IMPL_GW : evmask_pkg::RD_ZERO);

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    logic [5:0] pins_s;
    logic [N-1:0] state_s;
    logic         card_rst;

    sync2 #(.W(6)) u_sync (
        .clk  (clk),
        .rstn (rstn),
        .din  ({~card_rst_n_pin, general_wake_event, battery_level_low_bit,
                battery_level_high_bit, ready_pin, wp_pin}),
        .dout (pins_s)
    );

    // card reset enters inverted: the synchroniser's zero after reset
    // must not read as a card reset that wipes the audio enables
    // card reset low clears the non-kept fields each cycle; a mask write in that cycle wins
    assign card_rst = pins_s[5];
    assign state_s  = {pins_s[4] & GEN_WK_IMPL, pins_s[3:0]};

    // ------------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------------
    logic [7:0] a8;
    logic       hit_latch;
    logic       hit_mask;
    logic       hit_istat;
    logic       hit_imask;

    assign a8        = 8'(addr);
    assign hit_latch = (a8 == evmask_pkg::OFS_EVENT_LATCH);
    assign hit_mask  = (a8 == evmask_pkg::OFS_EVENT_MASK);
    assign hit_istat = (a8 == evmask_pkg::OFS_IRQ_STATUS);
    assign hit_imask = (a8 == evmask_pkg::OFS_IRQ_MASK);

    // ------------------------------------------------------------------
    // event latch
    // ------------------------------------------------------------------
    logic [N-1:0] evt;
    logic [N-1:0] evt_set;
    logic [N-1:0] evt_clr;
    logic [N-1:0] rise_only;

    assign evt_clr   = (wr && hit_latch) ? wdata[N-1:0] : '0;
    // ready fires on busy to ready only, general wake on 0 to 1 only
    assign rise_only = (N'(1) << evmask_pkg::EVT_READY) |
                       (N'(1) << evmask_pkg::EVT_GEN_WK);

    event_latch #(.N(N)) u_latch (
        .clk       (clk),
        .rstn      (rstn),
        .card_rst  (card_rst),
        .keep      (WAKE_CAP),
        .rise_only (rise_only),
        .state     (state_s),
        .clr       (evt_clr),
        .evt       (evt),
        .set_pulse (evt_set)
    );

    // ------------------------------------------------------------------
    // event enable mask register
    // ------------------------------------------------------------------
    // one private copy per instance: each function owns its own mask
    logic [31:0] mask_r;
    logic [31:0] keep_bits;

    // wake-capable enables and the master gate survive card reset
    assign keep_bits =
        ({31'h0, WAKE_CAP[evmask_pkg::EVT_WP]} << evmask_pkg::MSK_WP) |
        ({31'h0, WAKE_CAP[evmask_pkg::EVT_READY]} << evmask_pkg::MSK_READY) |
        ({30'h0, {2{WAKE_CAP[evmask_pkg::EVT_BATT_H] |
                    WAKE_CAP[evmask_pkg::EVT_BATT_L]}}}
            << evmask_pkg::MSK_BATT_LO) |
        ({31'h0, WAKE_CAP[evmask_pkg::EVT_GEN_WK]} << evmask_pkg::MSK_GEN_WK) |
        ({31'h0, |WAKE_CAP} << evmask_pkg::MSK_MASTER);

    always_ff @(posedge clk) begin
        if (!rstn) begin
            mask_r <= evmask_pkg::MASK_RESET;
        end else if (wr && hit_mask) begin
            mask_r <= wdata & IMPL;
        end else if (card_rst) begin
            mask_r <= mask_r & keep_bits;
        end
    end

    // ------------------------------------------------------------------
    // gating toward interrupt and wakeup
    // ------------------------------------------------------------------
    logic [N-1:0] en;
    logic [N-1:0] int_en;
    logic         batt_en;
    logic         master;
    logic         irq_nxt;
    logic         wake_nxt;

    // mixed battery codes are invalid; treated as blocked
    assign batt_en = (mask_r[evmask_pkg::MSK_BATT_HI:evmask_pkg::MSK_BATT_LO]
                      == evmask_pkg::BATT_ON);
    assign master  = mask_r[evmask_pkg::MSK_MASTER];
    assign en[evmask_pkg::EVT_WP]     = mask_r[evmask_pkg::MSK_WP];
    assign en[evmask_pkg::EVT_READY]  = mask_r[evmask_pkg::MSK_READY];
    assign en[evmask_pkg::EVT_BATT_H] = batt_en;
    assign en[evmask_pkg::EVT_BATT_L] = batt_en;
    assign en[evmask_pkg::EVT_GEN_WK] = mask_r[evmask_pkg::MSK_GEN_WK];
    // general wake never reaches the status-changed interrupt
    assign int_en = en & ~(N'(1) << evmask_pkg::EVT_GEN_WK);
    assign irq_nxt  = |(evt & int_en);
    assign wake_nxt = master && |(evt & en);

    always_ff @(posedge clk) begin
        if (!rstn) begin
            status_change_irq <= 1'b0;
            wake_req          <= 1'b0;
        end else begin
            status_change_irq <= irq_nxt;
            wake_req          <= wake_nxt;
        end
    end

    // ------------------------------------------------------------------
    // audio pin select
    // ------------------------------------------------------------------
    logic binary_audio_enable;
    logic pwm;

    assign binary_audio_enable = mask_r[evmask_pkg::MSK_BIN_AUD];
    assign pwm                 = mask_r[evmask_pkg::MSK_PWM];

    // both set is illegal; binary audio wins so the pin stays defined
    always_ff @(posedge clk) begin
        if (!rstn) begin
            card_audio_pin <= 1'b0;
        end else if (binary_audio_enable) begin
            card_audio_pin <= binary_audio_src;
        end else if (pwm) begin
            card_audio_pin <= pwm_audio_src;
        end else begin
            card_audio_pin <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // local interrupt status and mask
    // ------------------------------------------------------------------
    logic [N-1:0] istat_r;
    logic [N-1:0] imask_r;

    // a new event in the read-clear cycle stays set
    always_ff @(posedge clk) begin
        if (!rstn) begin
            istat_r <= evmask_pkg::EVT_RESET;
        end else if (rd && hit_istat) begin
            istat_r <= evt_set;
        end else begin
            istat_r <= istat_r | evt_set;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            imask_r <= evmask_pkg::EVT_RESET;
        end else if (wr && hit_imask) begin
            imask_r <= wdata[N-1:0];
        end
    end

    assign irq = |(istat_r & imask_r);

    // ------------------------------------------------------------------
    // read data, one cycle after the strobe
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rstn) begin
            rdata <= evmask_pkg::RD_ZERO;
        end else if (rd) begin
            if (hit_latch) begin
                rdata <= {27'h0, evt};
            end else if (hit_mask) begin
                rdata <= mask_r;
            end else if (hit_istat) begin
                rdata <= {27'h0, istat_r};
            end else if (hit_imask) begin
                rdata <= {27'h0, imask_r};
            end else begin
                rdata <= evmask_pkg::RD_ZERO;
            end
        end else begin
            rdata <= evmask_pkg::RD_ZERO;
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    sequence s_mask_wr;
        wr && hit_mask;
    endsequence

    sequence s_istat_rd;
        rd && hit_istat && !(|evt_set);
    endsequence

    irq_follows_mask_a: assert property (
        (evt[evmask_pkg::EVT_WP] && mask_r[evmask_pkg::MSK_WP])
        |=> status_change_irq)
        else $error("enabled wp event did not raise status irq");

    wake_master_off_a: assert property (
        !master |=> !wake_req)
        else $error("wakeup raised with master gate off");

    wake_needs_master_a: assert property (
        (evt[evmask_pkg::EVT_READY] && mask_r[evmask_pkg::MSK_READY] &&
         master) |=> wake_req)
        else $error("enabled ready event with master gave no wakeup");

    wake_no_irq_a: assert property (
        ((evt & ~(N'(1) << evmask_pkg::EVT_GEN_WK)) == '0)
        |=> !status_change_irq)
        else $error("general wake reached status irq");

    batt_mixed_block_a: assert property (
        (!batt_en && ((evt & 5'h13) == '0)) |=> !status_change_irq)
        else $error("battery event passed a blocked field");

    mask_wr_store_a: assert property (
        s_mask_wr |=> (mask_r == ($past(wdata) & IMPL)))
        else $error("mask write not stored");

    reserved_zero_a: assert property (
        (mask_r & ~IMPL) == '0)
        else $error("reserved mask bit set");

    card_rst_keep_a: assert property (
        (card_rst && !(wr && hit_mask)) |=> ((mask_r & ~keep_bits) == '0))
        else $error("non-kept mask bits survived card reset");

    audio_off_a: assert property (
        (!binary_audio_enable && !pwm) |=> !card_audio_pin)
        else $error("audio pin active with both enables clear");

    audio_pwm_a: assert property (
        (pwm && !binary_audio_enable)
        |=> (card_audio_pin == $past(pwm_audio_src)))
        else $error("pwm audio not routed to pin");

    istat_clear_a: assert property (
        s_istat_rd |=> (istat_r == '0))
        else $error("status read did not clear");

    mask_readback_a: assert property (
        (rd && hit_mask && !wr) |=> (rdata == $past(mask_r)))
        else $error("mask readback wrong");

    audio_binary_a: assert property (
        binary_audio_enable |=> (card_audio_pin == $past(binary_audio_src)))
        else $error("binary audio not routed to pin");

    gen_wake_req_a: assert property (
        (evt[evmask_pkg::EVT_GEN_WK] && mask_r[evmask_pkg::MSK_GEN_WK] &&
         master) |=> wake_req)
        else $error("enabled general wake with master gave no wakeup");

    batt_on_irq_a: assert property (
        (evt[evmask_pkg::EVT_BATT_L] && batt_en) |=> status_change_irq)
        else $error("enabled battery event did not raise status irq");

    istat_sticky_a: assert property (
        (|evt_set) |=> ((istat_r & $past(evt_set)) == $past(evt_set)))
        else $error("latched event missing from irq status");

    rdata_idle_a: assert property (
        !rd |=> (rdata == evmask_pkg::RD_ZERO))
        else $error("read data stood outside its read cycle");

    sequence s_latch_clr;
        (|evt_clr) && ((evt_clr & evt_set) == '0);
    endsequence

    latch_clear_a: assert property (
        s_latch_clr |=> ((evt & $past(evt_clr)) == '0))
        else $error("event latch write did not clear");

endmodule : event_mask_ctl
`default_nettype wire

// File: design/evmask_pkg.sv
// constants shared by the function event mask block
// assumes a 32-bit register port with byte offsets on word boundaries
package evmask_pkg;

    // ------------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_EVENT_LATCH = 8'h00;
    localparam logic [7:0] OFS_EVENT_MASK  = 8'h04;
    localparam logic [7:0] OFS_IRQ_STATUS  = 8'h08;
    localparam logic [7:0] OFS_IRQ_MASK    = 8'h0C;

    // ------------------------------------------------------------------
    // event numbering, shared by latch, mask and irq status
    // ------------------------------------------------------------------
    localparam int N_EVT      = 5;
    localparam int EVT_WP     = 0;
    localparam int EVT_READY  = 1;
    localparam int EVT_BATT_H = 2;
    localparam int EVT_BATT_L = 3;
    localparam int EVT_GEN_WK = 4;

    // ------------------------------------------------------------------
    // event_enable_mask field positions
    // ------------------------------------------------------------------
    localparam int MSK_WP      = 0;
    localparam int MSK_READY   = 1;
    localparam int MSK_BATT_LO = 2;
    localparam int MSK_BATT_HI = 3;
    localparam int MSK_GEN_WK  = 4;
    localparam int MSK_BIN_AUD = 5;
    localparam int MSK_PWM     = 6;
    localparam int MSK_MASTER  = 14;

    localparam logic [31:0] MASK_IMPL_BASE = 32'h0000_406F;
    localparam logic [31:0] MASK_IMPL_GW   = 32'h0000_0010;
    localparam logic [31:0] MASK_RESET     = 32'h0000_0000;
    localparam logic [1:0]  BATT_ON        = 2'h3;
    localparam logic [N_EVT-1:0] EVT_RESET = 5'h00;
    localparam logic [31:0] RD_ZERO        = 32'h0000_0000;

endpackage : evmask_pkg

// File: design/sync2.sv
// two-flop synchroniser for a bus of unrelated level inputs
// assumes each bit is an independent level; no word coherence
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rstn,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] meta_r;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            meta_r <= '0;
            dout   <= '0;
        end else begin
            meta_r <= din;
            dout   <= meta_r;
        end
    end
endmodule : sync2
`default_nettype wire

// File: design/event_latch.sv
// per-function event latch: sticky bits set on present-state changes
// assumes state inputs are already synchronised to clk
`timescale 1ns/1ps
`default_nettype none
module event_latch #(
    parameter int N = 5
) (
    input  wire logic         clk,
    input  wire logic         rstn,
    input  wire logic         card_rst,
    input  wire logic [N-1:0] keep,
    input  wire logic [N-1:0] rise_only,
    input  wire logic [N-1:0] state,
    input  wire logic [N-1:0] clr,
    output logic      [N-1:0] evt,
    output logic      [N-1:0] set_pulse
);
    logic [N-1:0] prev_r;
    logic [2:0]   primed_r;
    logic [N-1:0] hit;

    // state passes a two-flop synchroniser that reads zero for two cycles
    // after reset; changes count only once prev_r holds a real sample,
    // so a pin held high through reset is no event
    always_ff @(posedge clk) begin
        if (!rstn) begin
            prev_r   <= '0;
            primed_r <= '0;
        end else begin
            prev_r   <= state;
            primed_r <= {primed_r[1:0], 1'b1};
        end
    end

    genvar i;
    for (i = 0; i < N; i++) begin : g_bit
        assign hit[i] = primed_r[2] && (rise_only[i] ?
                        (state[i] && !prev_r[i]) : (state[i] != prev_r[i]));

        // a change in the clearing cycle keeps the bit set
        always_ff @(posedge clk) begin
            if (!rstn) begin
                evt[i] <= 1'b0;
            end else if (hit[i]) begin
                evt[i] <= 1'b1;
            end else if (clr[i] || (card_rst && !keep[i])) begin
                evt[i] <= 1'b0;
            end
        end
    end
    assign set_pulse = hit;
endmodule : event_latch
`default_nettype wire

// File: testbench/host_model.sv
// host side model: card services reaching the event mask registers
// assumes one clock; read data valid only in the cycle after the strobe
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input  wire logic        clk,
    output logic      [7:0]  addr,
    output logic      [31:0] wdata,
    output logic             wr,
    output logic             rd,
    input  wire logic [31:0] rdata
);
    // ------------------------------------------------------------------
    // idle bus
    // ------------------------------------------------------------------
    initial begin
        addr  = 8'h00;
        wdata = 32'h0000_0000;
        wr    = 1'b0;
        rd    = 1'b0;
    end

    // ------------------------------------------------------------------
    // software never hands the block an illegal mask pattern
    // ------------------------------------------------------------------
    function automatic logic [31:0] legal_value(input logic [31:0] v);
        logic [31:0] r;
        r = v;
        if (r[3] != r[2]) begin
            r[3:2] = 2'h0;
        end
        if (r[5] && r[6]) begin
            r[6] = 1'b0;
        end
        return r;
    endfunction : legal_value

    // ------------------------------------------------------------------
    // bus cycles
    // ------------------------------------------------------------------
    // address and data are inverted once released so stale values never
    // pass for a valid request
    task automatic write_reg(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] v;
        v = (a == evmask_pkg::OFS_EVENT_MASK) ? legal_value(d) : d;
        @(posedge clk);
        addr  <= a;
        wdata <= v;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
        addr  <= ~a;
        wdata <= ~v;
    endtask : write_reg

    task automatic read_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        addr <= ~a;
        #1;
        d = rdata;
    endtask : read_reg
endmodule : host_model
`default_nettype wire

// File: testbench/function_event_mask_bench.sv
// self-checking bench for the function event mask block
// assumes host_model drives the register port; pins driven here
`timescale 1ns/1ps
`default_nettype none
module function_event_mask_bench;
    logic        clk;
    logic        rstn;
    logic [4:0]  pins;
    logic        card_rst_n;
    logic        bin_src;
    logic        pwm_src;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
    logic [31:0] rdata;
    logic        status_change_irq;
    logic        wake_req;
    logic        card_audio_pin;
    logic        irq;
    int          errors;
    int          samples_checked;

    always #12.5 clk = ~clk;

    host_model host (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr),
                     .rd(rd), .rdata(rdata));

    event_mask_ctl #(.ADDR_W(8), .GEN_WK_IMPL(1'b1), .WAKE_CAP(5'h1F)) dut (
        .clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .wp_pin(pins[0]), .ready_pin(pins[1]),
        .battery_level_high_bit(pins[2]), .battery_level_low_bit(pins[3]),
        .general_wake_event(pins[4]), .card_rst_n_pin(card_rst_n),
        .binary_audio_src(bin_src), .pwm_audio_src(pwm_src),
        .status_change_irq(status_change_irq), .wake_req(wake_req),
        .card_audio_pin(card_audio_pin), .irq(irq));

    // ------------------------------------------------------------------
    // reporting
    // ------------------------------------------------------------------
    task automatic complete_run;
        if (errors == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : complete_run

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // bounded wait for {status_change_irq, wake_req}; a miss ends the run
    task automatic wait_out(input logic [1:0] exp);
        int n;
        n = 0;
        // outputs move two edges after a write; never judge the old value
        repeat (2) @(posedge clk);
        #1;
        while ({status_change_irq, wake_req} !== exp && n < 8) begin
            @(posedge clk);
            #1;
            n++;
        end
        check({30'h0, status_change_irq, wake_req}, {30'h0, exp});
        if ({status_change_irq, wake_req} !== exp) begin
            complete_run();
        end
    endtask : wait_out

    // six cycles covers pin-to-output latency of four
    task automatic hold_out(input logic [1:0] exp);
        repeat (6) @(posedge clk);
        #1;
        check({30'h0, status_change_irq, wake_req}, {30'h0, exp});
    endtask : hold_out

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic reset_values;
        logic [31:0] d;
        check({28'h0, status_change_irq, wake_req, card_audio_pin, irq},
              32'h0000_0000);
        host.read_reg(evmask_pkg::OFS_EVENT_MASK, d);
        check(d, 32'h0000_0000);
    endtask : reset_values

    task automatic reg_access;
        logic [31:0] d;
        host.write_reg(evmask_pkg::OFS_EVENT_MASK, 32'hFFFF_FFBF);
        host.read_reg(evmask_pkg::OFS_EVENT_MASK, d);
        check(d, 32'h0000_403F);
        host.write_reg(evmask_pkg::OFS_EVENT_MASK, 32'h0000_0040);
        host.write_reg(8'h10, 32'hFFFF_FFFF);
        host.read_reg(8'h10, d);
        check(d, 32'h0000_0000);
        host.read_reg(evmask_pkg::OFS_EVENT_MASK, d);
        check(d, 32'h0000_0040);
    endtask : reg_access

    task automatic event_path(input int i, input logic [31:0] en);
        logic [31:0] d;
        logic        irq_exp;
        irq_exp = (i != 4);
        host.write_reg(evmask_pkg::OFS_EVENT_MASK, 32'h0000_4000);
        @(posedge clk);
        pins[i] <= 1'b1;
        hold_out(2'b00);
        check({31'h0, irq}, 32'h0000_0000);
        host.read_reg(evmask_pkg::OFS_EVENT_LATCH, d);
        check(d, 32'h1 << i);
        host.write_reg(evmask_pkg::OFS_EVENT_MASK, en);
        wait_out({irq_exp, 1'b0});
        host.write_reg(evmask_pkg::OFS_EVENT_MASK, en | 32'h0000_4000);
        wait_out({irq_exp, 1'b1});
        host.write_reg(evmask_pkg::OFS_IRQ_MASK, 32'h1 << i);
        #1;
        check({31'h0, irq}, 32'h0000_0001);
        host.read_reg(evmask_pkg::OFS_IRQ_STATUS, d);
        check(d, 32'h1 << i);
        check({31'h0, irq}, 32'h0000_0000);
        host.write_reg(evmask_pkg::OFS_IRQ_MASK, 32'h0000_0000);
        host.write_reg(evmask_pkg::OFS_EVENT_LATCH, 32'h1 << i);
        wait_out(2'b00);
        // falling edges latch again for some events; flush them
        host.write_reg(evmask_pkg::OFS_EVENT_MASK, 32'h0000_0000);
        @(posedge clk);
        pins[i] <= 1'b0;
        repeat (6) @(posedge clk);
        host.write_reg(evmask_pkg::OFS_EVENT_LATCH, 32'h0000_001F);
        host.read_reg(evmask_pkg::OFS_IRQ_STATUS, d);
    endtask : event_path

    task automatic audio_select;
        for (int k = 0; k < 5; k++) begin
            @(posedge clk);
            bin_src <= (k == 0 || k == 3 || k == 4);
            pwm_src <= (k == 1 || k == 2 || k == 4);
            host.write_reg(evmask_pkg::OFS_EVENT_MASK,
                           k < 2 ? 32'h20 : (k < 4 ? 32'h40 : 32'h0));
            repeat (2) @(posedge clk);
            #1;
            check({31'h0, card_audio_pin},
                  {31'h0, k == 0 || k == 2});
        end
    endtask : audio_select

    task automatic card_reset;
        logic [31:0] d;
        host.write_reg(evmask_pkg::OFS_EVENT_MASK, 32'h0000_403F);
        @(posedge clk);
        card_rst_n <= 1'b0;
        repeat (4) @(posedge clk);
        card_rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        host.read_reg(evmask_pkg::OFS_EVENT_MASK, d);
        check(d, 32'h0000_401F);
    endtask : card_reset

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        clk             = 1'b0;
        rstn            = 1'b0;
        pins            = 5'h00;
        card_rst_n      = 1'b1;
        bin_src         = 1'b0;
        pwm_src         = 1'b0;
        errors          = 0;
        samples_checked = 0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        #1;
        reset_values();
        reg_access();
        event_path(0, 32'h0000_0001);
        event_path(1, 32'h0000_0002);
        event_path(2, 32'h0000_000C);
        event_path(3, 32'h0000_000C);
        event_path(4, 32'h0000_0010);
        audio_select();
        card_reset();
        complete_run();
    end
endmodule : function_event_mask_bench
`default_nettype wire
